/* sia_host_model.sv */
`default_nettype none
module sia_host_model (
  input wire logic ref_clk_in, // Clock
  input wire logic req_in, // Start a read frame
  input wire logic [2:0] addr_in, // Register to read
  input wire logic oe_in, // Device pulls pin low
  input wire logic strap_in, // Board pull level
  input wire logic ro_in, // Request is a read-only command
  input wire logic drive_in, // Level driven while enabled
  output logic pin_out, // Resolved pin level
  output logic done_out, // Chip select released
  output logic ro_out, // Read-only command
  output logic [2:0] addr_out // Frame register
);
  logic [2:0] cnt = 3'h0;
  logic [2:0] last = 3'h0;
  logic ro_last = 1'b0;
  assign pin_out = oe_in ? drive_in : strap_in;
  // Command kind is held with the address until the strobe
  assign ro_out = done_out & ro_last;
  // Address is only valid with the strobe
  assign addr_out = done_out ? last : ~last;
  always_ff @(posedge ref_clk_in) begin
    if (req_in) begin
      last <= addr_in;
      ro_last <= ro_in;
      cnt <= 3'h4;
    end else if (cnt != 3'h0) begin
      cnt <= cnt - 3'h1;
    end
    done_out <= (cnt == 3'h1);
  end
endmodule
`default_nettype wire

/* sia_interval_timer.sv */
`default_nettype none
module sia_interval_timer
  import sia_pkg::*;
(
  input wire logic ref_clk_in, // Oscillator clock
  input wire logic sys_rst_in, // Async reset, high
  input wire logic load_in, // Restart the count
  input wire logic [TMR_W-1:0] load_val_in, // Cycles to run
  output logic [TMR_W-1:0] remain_out, // Cycles left
  output logic expired_out // Count at zero
);
  typedef struct packed {
    logic [TMR_W-1:0] cnt;
    logic expired;
  } sia_tmr_t;

  sia_tmr_t st;
  sia_tmr_t next_st;

  always_comb begin
    next_st = st;
    if (load_in) begin
      next_st.cnt = load_val_in;
    end else if (st.cnt != '0) begin
      next_st.cnt = st.cnt - 1'b1;
    end
    next_st.expired = (next_st.cnt == '0);
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st <= '{cnt: '0, expired: 1'b1};
    end else begin
      st <= next_st;
    end
  end

  assign remain_out = st.cnt;
  assign expired_out = st.expired;
endmodule
`default_nettype wire

/* sia_irq_aggregator.sv */
// Contract
// - Unmasked source event pulls interrupt pin low
// - Every source has its own mask bit
// - Masked sources still set readable status bits
// - Undervoltage raises on appearing and disappearing
// - State bits latch until read, then follow
// - Failure and wake bits: event, cleared by read
// - Pin released by register 000 read or timeout
// - Wakes shown in register 000, cleared reading
// - Non-wake sources set summary bit in 000
// - Read-only clears event bits; state bits stay set only while live
// - Summary clears only when 001, 010 empty
// - During startup pin sampled as configuration strap
// - Temperature sources trigger on rising edge
// - Overcurrent rising, ignored while regulator inhibited
// - Regulator switch-on command raises undervoltage event
// - No undervoltage interrupt when regulator switched off
// - Chip failures rising events; reset only development
// - Timers run from internal oscillator, ten percent
// - Low phase ends after interrupt timeout
// - Low pulse lasts at least ten microseconds
// - Gap of one timeout between pulses; stored
// - Several pending sources give one pulse
`default_nettype none
module sia_irq_aggregator
  import sia_pkg::*;
#(
  parameter int TIMEOUT_CYC = IRQ_TIMEOUT_CYC
) (
  input wire logic ref_clk_in, // Internal oscillator clock
  input wire logic sys_rst_in, // Async reset, high
  input wire logic reset_out_n_in, // Chip reset output level, low = startup
  input wire logic sw_dev_mode_in, // Software development mode
  input wire logic heat_warn_main_in, // Main supply heat pre-warning
  input wire logic heat_supply_b_in, // Second regulator overtemperature
  input wire logic bus_xcvr_heat_in, // Bus transceiver overtemperature
  input wire logic bus_a_fail_in, // Bus A failure
  input wire logic bus_b_fail_in, // Bus B failure
  input wire logic supply_b_low_in, // Second regulator undervoltage
  input wire logic supply_c_low_in, // Third regulator undervoltage
  input wire logic supply_b_on_in, // Second regulator switched on
  input wire logic supply_c_on_in, // Third regulator switched on
  input wire logic supply_c_overcur_in, // Third regulator overcurrent
  input wire logic supply_c_inhibit_in, // Third regulator inhibited
  input wire logic spi_corrupt_in, // Corrupted frame seen
  input wire logic reset_event_in, // Reset event
  input wire logic bad_guard_cfg_in, // Bad watchdog setting
  input wire logic bus_a_wake_in, // Wake on bus A
  input wire logic bus_b_wake_in, // Wake on bus B
  input wire logic pin_wake_in, // Wake on wake pin
  input wire logic periodic_wake_in, // Periodic wake
  input wire logic [NSRC-1:0] mask_in, // Source enables, 1 = may drive pin
  input wire logic frame_done_in, // Pulse: chip select released
  input wire logic frame_read_only_in, // Finished frame was read-only
  input wire logic [2:0] frame_addr_in, // Register of finished frame
  input wire logic irq_pin_in, // Interrupt pin level
  output logic irq_pin_out, // Pin drive value, always low
  output logic irq_pin_oe_out, // Pin pulled low while high
  output logic cfg_group_out, // Strap: 0 = group 1/3, 1 = group 2/4
  output logic [NSRC-1:0] flags_out, // Source status bits
  output logic summary_flag_out // Summary bit of register 000
);
  localparam logic [TMR_W-1:0] TMO = TMR_W'(TIMEOUT_CYC);
  localparam logic [TMR_W-1:0] MIN_LEFT = TMR_W'(TIMEOUT_CYC - IRQ_MIN_PULSE_CYC);

  typedef struct packed {
    sia_irq_state_t state;
    logic [NSRC-1:0] flags;
    logic [NSRC-1:0] prev;
    logic prev_b_on;
    logic prev_c_on;
    logic pending;
    logic read_seen;
    logic cfg_group;
    logic summary;
    logic oe;
  } sia_agg_t;

  sia_agg_t st;
  sia_agg_t next_st;
  logic tmr_load;
  logic [TMR_W-1:0] tmr_remain;
  logic tmr_expired;
  logic [NSRC-1:0] live;
  logic [NSRC-1:0] set;
  logic [NSRC-1:0] clr;
  logic read0;
  logic new_irq;

  // Timer on the internal oscillator; its tolerance shifts both periods alike
  sia_interval_timer u_tmr (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .load_in(tmr_load),
    .load_val_in(TMO),
    .remain_out(tmr_remain),
    .expired_out(tmr_expired)
  );

  always_comb begin
    live = '0;
    live[SRC_HEAT_WARN_MAIN] = heat_warn_main_in;
    live[SRC_HEAT_SUPPLY_B] = heat_supply_b_in;
    live[SRC_BUS_XCVR_HEAT] = bus_xcvr_heat_in;
    live[SRC_BUS_A_FAIL] = bus_a_fail_in;
    live[SRC_BUS_B_FAIL] = bus_b_fail_in;
    live[SRC_SUPPLY_B_LOW] = supply_b_low_in & supply_b_on_in;
    live[SRC_SUPPLY_C_LOW] = supply_c_low_in & supply_c_on_in;
    live[SRC_SUPPLY_C_OVERCUR] = supply_c_overcur_in & ~supply_c_inhibit_in;
    live[SRC_SPI_CORRUPT] = spi_corrupt_in;
    live[SRC_RESET_EVT] = reset_event_in & sw_dev_mode_in;
    live[SRC_BAD_GUARD_CFG] = bad_guard_cfg_in;
    live[SRC_BUS_A_WAKE] = bus_a_wake_in;
    live[SRC_BUS_B_WAKE] = bus_b_wake_in;
    live[SRC_PIN_WAKE] = pin_wake_in;
    live[SRC_PERIODIC_WAKE] = periodic_wake_in;

    // Every source is rising-edge sensitive
    set = live & ~st.prev;
    // Recovery only counts while the regulator stays on
    set[SRC_SUPPLY_B_LOW] = set[SRC_SUPPLY_B_LOW] |
      (st.prev[SRC_SUPPLY_B_LOW] & ~supply_b_low_in & supply_b_on_in & st.prev_b_on) |
      (supply_b_on_in & ~st.prev_b_on);
    set[SRC_SUPPLY_C_LOW] = set[SRC_SUPPLY_C_LOW] |
      (st.prev[SRC_SUPPLY_C_LOW] & ~supply_c_low_in & supply_c_on_in & st.prev_c_on) |
      (supply_c_on_in & ~st.prev_c_on);

    // Clearing only at frame end, so bits read mid-frame stay coherent
    read0 = frame_done_in & frame_read_only_in & (frame_addr_in == IRQ_REG0);
    clr = '0;
    if (frame_done_in & frame_read_only_in) begin
      case (frame_addr_in)
        IRQ_REG0: clr = REG0_BITS;
        IRQ_REG1: clr = REG1_BITS;
        IRQ_REG2: clr = REG2_BITS;
        default: clr = '0;
      endcase
    end

    // Masks gate only the pin, never the status bits
    new_irq = |(set & mask_in);

    next_st = st;
    next_st.prev = live;
    next_st.prev_b_on = supply_b_on_in;
    next_st.prev_c_on = supply_c_on_in;
    // Set wins over clear; state bits fall back to live level after a read
    next_st.flags = (st.flags & ~clr) | (clr & STATE_BITS & live) | set;
    next_st.summary = |(next_st.flags & ~REG0_BITS);
    tmr_load = 1'b0;

    if (!reset_out_n_in) begin
      // Pin is an input while the chip is in startup
      next_st.cfg_group = irq_pin_in;
      next_st.state = SIA_IDLE;
      next_st.oe = 1'b0;
      next_st.pending = 1'b0;
      next_st.read_seen = 1'b0;
    end else begin
      case (st.state)
        SIA_IDLE: begin
          if (st.pending | new_irq) begin
            next_st.state = SIA_LOW;
            next_st.oe = 1'b1;
            next_st.pending = 1'b0;
            next_st.read_seen = 1'b0;
            tmr_load = 1'b1;
          end
        end
        SIA_LOW: begin
          // Further events fold into this pulse
          next_st.read_seen = st.read_seen | read0;
          if (tmr_expired || ((st.read_seen | read0) && tmr_remain <= MIN_LEFT)) begin
            next_st.state = SIA_GAP;
            next_st.oe = 1'b0;
            tmr_load = 1'b1;
          end
        end
        SIA_GAP: begin
          next_st.pending = st.pending | new_irq;
          if (tmr_expired) begin
            next_st.state = SIA_IDLE;
          end
        end
        default: begin
          next_st.state = SIA_IDLE;
          next_st.oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st <= '{state: SIA_IDLE, flags: FLAGS_RST, prev: '0, prev_b_on: 1'b0, prev_c_on: 1'b0,
              pending: 1'b0, read_seen: 1'b0, cfg_group: CFG_GROUP_RST, summary: 1'b0, oe: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign irq_pin_out = 1'b0;
  assign irq_pin_oe_out = st.oe;
  assign cfg_group_out = st.cfg_group;
  assign flags_out = st.flags;
  assign summary_flag_out = st.summary;
endmodule
`default_nettype wire

/* sia_irq_asserts.sv */
`default_nettype none
module sia_irq_asserts
  import sia_pkg::*;
#(
  parameter int TIMEOUT_CYC = IRQ_TIMEOUT_CYC
) (
  input wire logic ref_clk_in, // Clock
  input wire logic sys_rst_in, // Reset
  input wire logic reset_out_n_in, // Startup when low
  input wire logic sw_dev_mode_in, // Dev mode
  input wire logic supply_c_inhibit_in, // Inhibit
  input wire logic bus_a_wake_in, // Wake A
  input wire logic frame_done_in, // Frame end
  input wire logic frame_read_only_in, // Read-only
  input wire logic [2:0] frame_addr_in, // Frame register
  input wire logic irq_pin_in, // Pin level
  input wire logic irq_pin_oe_out, // Pin drive
  input wire logic cfg_group_out, // Strap
  input wire logic [NSRC-1:0] flags_out, // Status
  input wire logic summary_flag_out // Summary
);
  logic [15:0] hi;
  logic [15:0] lo;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  // Low count saturates so the first pulse after reset is never flagged
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      hi <= 16'h0;
      lo <= 16'hffff;
    end else begin
      hi <= irq_pin_oe_out ? hi + 16'h1 : 16'h0;
      lo <= irq_pin_oe_out ? 16'h0 : lo + 16'(lo != 16'hffff);
    end
  end
  a_pulse_min: assert property ($fell(irq_pin_oe_out) |-> hi >= IRQ_MIN_PULSE_CYC)
    else $error("pin pulse too short");
  a_pulse_max: assert property (irq_pin_oe_out |-> hi <= TIMEOUT_CYC + 1)
    else $error("pin held past timeout");
  a_gap_hold: assert property ($rose(irq_pin_oe_out) |-> lo >= TIMEOUT_CYC - 1)
    else $error("pin pulses too close");
  a_strap_follow: assert property (!reset_out_n_in |=> cfg_group_out == $past(irq_pin_in))
    else $error("strap not sampled");
  a_summary_or: assert property (summary_flag_out == |flags_out[10:0])
    else $error("summary bit wrong");
  a_wake_set: assert property ($rose(bus_a_wake_in) |=> flags_out[SRC_BUS_A_WAKE])
    else $error("wake not recorded");
  a_read_clear: assert property (
    frame_done_in && frame_read_only_in && frame_addr_in == IRQ_REG0 && !$past(sys_rst_in)
    && !$rose(bus_a_wake_in) |=> !flags_out[SRC_BUS_A_WAKE]) else $error("wake not cleared");
  a_inhibit_block: assert property (
    supply_c_inhibit_in && !frame_done_in && !flags_out[SRC_SUPPLY_C_OVERCUR]
    |=> !flags_out[SRC_SUPPLY_C_OVERCUR]) else $error("overcurrent while inhibited");
  a_dev_gate: assert property (
    !sw_dev_mode_in && !frame_done_in && !flags_out[SRC_RESET_EVT] |=> !flags_out[SRC_RESET_EVT])
    else $error("reset event outside dev mode");
endmodule
bind sia_irq_aggregator sia_irq_asserts #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_sia_chk (
  .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .reset_out_n_in(reset_out_n_in),
  .sw_dev_mode_in(sw_dev_mode_in), .supply_c_inhibit_in(supply_c_inhibit_in), .bus_a_wake_in(bus_a_wake_in),
  .frame_done_in(frame_done_in), .frame_read_only_in(frame_read_only_in), .frame_addr_in(frame_addr_in),
  .irq_pin_in(irq_pin_in), .irq_pin_oe_out(irq_pin_oe_out), .cfg_group_out(cfg_group_out),
  .flags_out(flags_out), .summary_flag_out(summary_flag_out));
`default_nettype wire

/* sia_pkg.sv */
`default_nettype none
package sia_pkg;
  localparam int CLK_MHZ = 10;
  localparam int IRQ_TIMEOUT_US = 6000;
  localparam int IRQ_MIN_PULSE_US = 10;
  localparam int IRQ_TIMEOUT_CYC = IRQ_TIMEOUT_US * CLK_MHZ;
  localparam int IRQ_MIN_PULSE_CYC = IRQ_MIN_PULSE_US * CLK_MHZ;
  localparam int TMR_W = 16;
  localparam int NSRC = 15;

  // Source bit positions
  localparam int SRC_HEAT_WARN_MAIN = 0;
  localparam int SRC_HEAT_SUPPLY_B = 1;
  localparam int SRC_BUS_XCVR_HEAT = 2;
  localparam int SRC_BUS_A_FAIL = 3;
  localparam int SRC_BUS_B_FAIL = 4;
  localparam int SRC_SUPPLY_B_LOW = 5;
  localparam int SRC_SUPPLY_C_LOW = 6;
  localparam int SRC_SUPPLY_C_OVERCUR = 7;
  localparam int SRC_SPI_CORRUPT = 8;
  localparam int SRC_RESET_EVT = 9;
  localparam int SRC_BAD_GUARD_CFG = 10;
  localparam int SRC_BUS_A_WAKE = 11;
  localparam int SRC_BUS_B_WAKE = 12;
  localparam int SRC_PIN_WAKE = 13;
  localparam int SRC_PERIODIC_WAKE = 14;

  // Bits that follow their live condition once read
  localparam logic [NSRC-1:0] STATE_BITS = 15'h00ff;
  // Which bits each readable interrupt register holds
  localparam logic [NSRC-1:0] REG0_BITS = 15'h7800;
  localparam logic [NSRC-1:0] REG1_BITS = 15'h001f;
  localparam logic [NSRC-1:0] REG2_BITS = 15'h07e0;
  localparam logic [2:0] IRQ_REG0 = 3'h0;
  localparam logic [2:0] IRQ_REG1 = 3'h1;
  localparam logic [2:0] IRQ_REG2 = 3'h2;
  localparam logic [NSRC-1:0] FLAGS_RST = 15'h0000;
  localparam logic CFG_GROUP_RST = 1'h0;

  typedef enum logic [1:0] {
    SIA_IDLE = 2'b00,
    SIA_LOW = 2'b01,
    SIA_GAP = 2'b10
  } sia_irq_state_t;
endpackage
`default_nettype wire

/* tb_top.sv */
`default_nettype none
module tb_top
  import sia_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TO = 300;
  logic clk = 0, rst = 1, ron = 0, dev = 1, on_b = 0, on_c = 0, inh = 0, strap = 1, req = 0, m;
  logic [2:0] ra = 3'h0;
  logic [NSRC-1:0] s = '0, msk = '1, fl;
  logic fd, fro, pin, oe, cfg, drv, sum;
  logic ro = 1;
  logic [2:0] fa;
  int mismatches = 0, num_checks = 0, seed = 12;
  sia_irq_aggregator #(.TIMEOUT_CYC(TO)) dut (
    .ref_clk_in(clk), .sys_rst_in(rst), .reset_out_n_in(ron), .sw_dev_mode_in(dev),
    .heat_warn_main_in(s[0]), .heat_supply_b_in(s[1]), .bus_xcvr_heat_in(s[2]), .bus_a_fail_in(s[3]),
    .bus_b_fail_in(s[4]), .supply_b_low_in(s[5]), .supply_c_low_in(s[6]), .supply_b_on_in(on_b),
    .supply_c_on_in(on_c), .supply_c_overcur_in(s[7]), .supply_c_inhibit_in(inh), .spi_corrupt_in(s[8]),
    .reset_event_in(s[9]), .bad_guard_cfg_in(s[10]), .bus_a_wake_in(s[11]), .bus_b_wake_in(s[12]),
    .pin_wake_in(s[13]), .periodic_wake_in(s[14]), .mask_in(msk), .frame_done_in(fd),
    .frame_read_only_in(fro), .frame_addr_in(fa), .irq_pin_in(pin), .irq_pin_out(drv), .irq_pin_oe_out(oe),
    .cfg_group_out(cfg), .flags_out(fl), .summary_flag_out(sum));
  sia_host_model host (.ref_clk_in(clk), .req_in(req), .addr_in(ra), .oe_in(oe), .strap_in(strap),
    .ro_in(ro), .drive_in(drv),
    .pin_out(pin), .done_out(fd), .ro_out(fro), .addr_out(fa));
  initial forever #50 clk = ~clk;
  task automatic tick(int n = 1);
    repeat (n) @(posedge clk);
    #10;
  endtask
  task automatic chk(logic a, logic e, string t);
    num_checks++;
    if (a !== e) begin
      mismatches++;
      $display("Error %0t: %s", $time, t);
    end
  endtask
  task automatic rd(logic [2:0] a, logic r = 1'b1);
    ra = a;
    ro = r;
    req = 1;
    tick();
    req = 0;
    tick(6);
  endtask
  function automatic logic [2:0] reg_of(int i);
    return REG0_BITS[i] ? IRQ_REG0 : (REG1_BITS[i] ? IRQ_REG1 : IRQ_REG2);
  endfunction
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #2000000;
    mismatches++;
    report_and_stop();
  end
  initial begin
    tick(16);
    rst = 0;
    tick(2);
    chk(cfg, 1'b1, "strap");
    chk(oe, 1'b0, "pin driven in startup");
    ron = 1;
    tick();
    on_b = 1;
    on_c = 1;
    tick(2);
    chk(fl[5] & fl[6], 1'b1, "switch-on");
    tick(TO + 5);
    chk(oe, 1'b0, "timeout");
    rd(IRQ_REG2);
    s[0] = 1;
    tick(3);
    chk(oe, 1'b0, "pulse in gap");
    tick(TO);
    chk(oe, 1'b1, "stored event");
    chk(pin, 1'b0, "pin not low");
    s[0] = 0;
    tick(100);
    chk(fl[0], 1'b1, "latched");
    chk(sum, 1'b1, "summary set");
    rd(IRQ_REG0);
    chk(oe, 1'b0, "read release");
    rd(IRQ_REG1);
    chk(fl[0], 1'b0, "state clear");
    chk(sum, 1'b0, "summary clear");
    for (int i = 0; i < NSRC; i++) begin
      tick(TO + 5);
      m = 1'($random(seed));
      msk = NSRC'($random(seed));
      msk[i] = m;
      s[i] = 1;
      tick(2);
      chk(fl[i], 1'b1, "set");
      chk(oe, m, "mask");
      s[i] = 0;
      tick(2);
      // Undervoltage recovery is itself an event
      if (i == 5 || i == 6) chk(fl[i], 1'b1, "recovery");
      tick(110);
      rd(reg_of(i), 1'b0);
      chk(fl[i], 1'b1, "non-read-only kept");
      rd(reg_of(i));
      rd(IRQ_REG0);
      chk(fl[i], 1'b0, "clear");
      chk(oe, 1'b0, "release");
    end
    tick(TO + 5);
    msk = '1;
    inh = 1;
    dev = 0;
    on_b = 0;
    strap = 0;
    s[7] = 1;
    s[9] = 1;
    tick(2);
    s[5] = 1;
    tick(2);
    chk(fl[7], 1'b0, "inhibited");
    chk(fl[9], 1'b0, "dev mode");
    chk(fl[5], 1'b0, "regulator off");
    chk(oe, 1'b0, "no pulse");
    chk(cfg, 1'b1, "strap moved after startup");
    report_and_stop();
  end
endmodule
`default_nettype wire
